// File: core/fsga_arbiter.sv
// Fail-safe gate arbiter: override, faults, fail-safe and PWM control of the gate
`timescale 1ns/10ps
`include "fsga_regs.svh"

// Contract
// RL1: Low fail-safe enable enters fail-safe; gate follows fail-safe gate command.
// RL2: In fail-safe mode both PWM inputs are ignored.
// RL3: Outside logic supplies cross-conduction and deadtime protection during fail-safe.
// RL4: Fail-safe enable filter is much longer than other input filters. Code: on entry only; release uses the short input filter length.
// RL5: Entry filter length chosen by fail-safe gate command level.
// RL6: High-voltage-side fault holds gate off regardless of fail-safe inputs.
// RL7: Interrupt B low during fail-safe only when report bit set; resets 0.
// RL8: On exit the handover delay depends on PWM input state.
// RL9: PWM or command change between short and long delay hands over at once.
// RL10: Normal mandatory deadtime applies to PWM inputs after handover.
// RL11: No extra exit delay when PWM request equals fail-safe gate state.
// RL12: Matching request hands over when short exit delay expires.
// RL13: Active override input turns gate on, independent of other inputs.
// RL14: Override input high drives interrupt B low; interrupt A unchanged.
// RL15: Override takes effect only after minimum delay from its rising edge.
// RL16: Override outranks PWM, fail-safe inputs and all faults.
// RL17: Override still drives gate high during supply undervoltage.
// RL18: Override input level and gate state are reported as status.
// RL19: Override acts only when override-enable bit set; then gate high.
// RL20: Unused override input tied low and enable bit cleared by system.
// RL21: Filter durations and exit delays are design parameters.
module fsga_arbiter import fsga_pkg::*; #(
  parameter int CW = 16, // Width of every counter
  parameter int IN_FILT_CYC = `FSGA_IN_FILT_CYC, // RL21
  parameter int ENTRY_OFF_CYC = `FSGA_ENTRY_OFF_CYC, // RL21
  parameter int ENTRY_ON_CYC = `FSGA_ENTRY_ON_CYC, // RL21
  parameter int EXIT_SHORT_CYC = `FSGA_EXIT_SHORT_CYC, // RL21
  parameter int EXIT_LONG_CYC = `FSGA_EXIT_LONG_CYC, // RL21
  parameter int OVR_CYC = `FSGA_OVR_CYC, // Override delay
  parameter int DEADTIME_CYC = `FSGA_DEADTIME_CYC // Mandatory deadtime
) (
  input wire logic clk, // 200 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire logic pwm_in, // PWM pin
  input wire logic complementary_pwm_in, // Opposite-side PWM pin
  input wire logic failsafe_enable_n, // Fail-safe enable pin, active low
  input wire logic failsafe_gate_cmd, // Gate state wanted in fail-safe
  input wire logic hv_override_in, // High-voltage-side override pin
  input wire logic hv_fault, // Any HV-side fault, same clock domain
  input wire logic hv_override_enable, // Config: override allowed
  input wire logic irq_b_reports_failsafe, // Config: interrupt B shows fail-safe
  output logic gate_on, // Gate drive command, high = on
  output logic failsafe_active, // Gate not under PWM control
  output logic fault_irq_a_n, // Interrupt A, active low
  output logic fault_irq_b_n, // Interrupt B, active low
  output logic status_override_level, // Filtered override pin level
  output logic status_gate_on // Present gate state
);

  // ============================================================
  // Filtered inputs
  logic pwm_f;
  logic comp_f;
  logic cmd_f;
  logic en_n_f;
  logic ovr_f;
  logic [CW-1:0] in_len;
  logic [CW-1:0] en_len;

  assign in_len = CW'(IN_FILT_CYC);

  // Long entry filter picked by the command level; release uses the short
  // glitch filter because the exit timing is done by the state machine
  always_comb begin
    if (!en_n_f) begin
      en_len = in_len;
    end else if (cmd_f) begin
      en_len = CW'(ENTRY_ON_CYC); // RL4 RL5
    end else begin
      en_len = CW'(ENTRY_OFF_CYC); // RL4 RL5
    end
  end

  fsga_filter #(.CW(CW), .RST_VAL(`FSGA_RST_LOW)) u_pwm_filt (
    .clk(clk),
    .reset(reset),
    .raw_in(pwm_in),
    .len(in_len),
    .filt_out(pwm_f)
  );

  // Opposite PWM resets high so the gate stays off until it is seen low
  fsga_filter #(.CW(CW), .RST_VAL(`FSGA_RST_COMP)) u_comp_filt (
    .clk(clk),
    .reset(reset),
    .raw_in(complementary_pwm_in),
    .len(in_len),
    .filt_out(comp_f)
  );

  fsga_filter #(.CW(CW), .RST_VAL(`FSGA_RST_LOW)) u_cmd_filt (
    .clk(clk),
    .reset(reset),
    .raw_in(failsafe_gate_cmd),
    .len(in_len),
    .filt_out(cmd_f)
  );

  fsga_filter #(.CW(CW), .RST_VAL(`FSGA_RST_EN_N)) u_en_filt (
    .clk(clk),
    .reset(reset),
    .raw_in(failsafe_enable_n),
    .len(en_len),
    .filt_out(en_n_f)
  );

  fsga_filter #(.CW(CW), .RST_VAL(`FSGA_RST_LOW)) u_ovr_filt (
    .clk(clk),
    .reset(reset),
    .raw_in(hv_override_in),
    .len(in_len),
    .filt_out(ovr_f)
  );

  // ============================================================
  // Module state
  typedef struct packed {
    fsga_state_t state;
    logic [CW-1:0] exit_cnt;
    logic match;
    logic snap_pwm;
    logic snap_cmd;
    logic [CW-1:0] dt_cnt;
    logic [CW-1:0] ovr_cnt;
    logic ovr_act;
    logic gate;
    logic irq_a_n;
    logic irq_b_n;
  } fsga_core_t;

  localparam fsga_core_t CORE_RST = '{
    state: FSGA_PWM_CTRL,
    exit_cnt: '0,
    match: 1'b0,
    snap_pwm: 1'b0,
    snap_cmd: 1'b0,
    dt_cnt: CW'(DEADTIME_CYC),
    ovr_cnt: '0,
    ovr_act: 1'b0,
    gate: `FSGA_RST_GATE,
    irq_a_n: `FSGA_RST_IRQ_N,
    irq_b_n: `FSGA_RST_IRQ_N
  };

  fsga_core_t s_q;
  fsga_core_t s_d;
  logic pwm_req;
  logic pwm_gate;
  logic short_done;
  logic long_done;
  logic changed;

  // Gate state asked for by the PWM pair
  assign pwm_req = pwm_f & ~comp_f;

  // Deadtime: opposite side must have been low for the full count, and a
  // rising opposite side turns the gate off at once without waiting
  assign pwm_gate = pwm_req && (s_q.dt_cnt == '0); // RL10

  // Exit timing decodes
  assign short_done = (s_q.exit_cnt + CW'(1) >= CW'(EXIT_SHORT_CYC));
  assign long_done = (s_q.exit_cnt + CW'(1) >= CW'(EXIT_LONG_CYC));
  assign changed = (pwm_req != s_q.snap_pwm) || (cmd_f != s_q.snap_cmd);

  // ============================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;

    // Deadtime counter reloads while the opposite side is high
    if (comp_f) begin
      s_d.dt_cnt = CW'(DEADTIME_CYC); // RL10
    end else if (s_q.dt_cnt != '0) begin
      s_d.dt_cnt = s_q.dt_cnt - CW'(1);
    end

    // Override qualifies only when enabled and held past its delay;
    // dropping the pin or the enable ends it at once
    if (ovr_f && hv_override_enable) begin // RL19
      if (s_q.ovr_cnt + CW'(1) >= CW'(OVR_CYC)) begin
        s_d.ovr_act = 1'b1; // RL15
      end else begin
        s_d.ovr_cnt = s_q.ovr_cnt + CW'(1);
      end
    end else begin
      s_d.ovr_cnt = '0;
      s_d.ovr_act = 1'b0;
    end

    // Control owner
    case (s_q.state)
      FSGA_PWM_CTRL: begin
        if (!en_n_f) begin
          s_d.state = FSGA_FS_CTRL; // RL1
        end
      end
      FSGA_FS_CTRL: begin
        if (en_n_f) begin
          // Remember what PWM wants against the fail-safe gate state
          s_d.state = FSGA_EXIT_WAIT; // RL8
          s_d.exit_cnt = '0;
          s_d.match = (pwm_req == cmd_f); // RL11
          s_d.snap_pwm = pwm_req;
          s_d.snap_cmd = cmd_f;
        end
      end
      FSGA_EXIT_WAIT: begin
        s_d.exit_cnt = s_q.exit_cnt + CW'(1);
        if (!en_n_f) begin
          s_d.state = FSGA_FS_CTRL; // Re-entry wins over handover
        end else if (short_done && s_q.match) begin
          s_d.state = FSGA_PWM_CTRL; // RL11 RL12
        end else if (short_done && changed) begin
          s_d.state = FSGA_PWM_CTRL; // RL9
        end else if (long_done) begin
          s_d.state = FSGA_PWM_CTRL; // RL8
        end
      end
      default: begin
        s_d.state = FSGA_FS_CTRL; // Unknown code falls to the safe owner
      end
    endcase

    // Gate priority: override, then HV faults, then the owner
    if (s_q.ovr_act) begin
      s_d.gate = 1'b1; // RL13 RL16 RL17 RL19
    end else if (hv_fault) begin
      s_d.gate = 1'b0; // RL6
    end else if (s_q.state == FSGA_PWM_CTRL) begin
      s_d.gate = pwm_gate; // RL10
    end else begin
      s_d.gate = cmd_f; // RL1 RL2
    end

    // Interrupt A tracks faults only, override does not touch it
    s_d.irq_a_n = ~hv_fault; // RL14
    // Interrupt B: faults, override pin, and fail-safe when asked for
    s_d.irq_b_n = ~(hv_fault || ovr_f // RL14
                    || (irq_b_reports_failsafe && !en_n_f)); // RL7

    if (reset) begin
      s_d = CORE_RST; // RL7
    end
  end

  // State register
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // ============================================================
  // Outputs, all from flip-flops except failsafe_active, decoded from the state
  assign gate_on = s_q.gate;
  assign failsafe_active = (s_q.state != FSGA_PWM_CTRL);
  assign fault_irq_a_n = s_q.irq_a_n;
  assign fault_irq_b_n = s_q.irq_b_n;
  assign status_override_level = ovr_f; // RL18
  assign status_gate_on = s_q.gate; // RL18

  // ============================================================
  // Checks

  AST_OVR_WINS: assert property (@(posedge clk) disable iff (reset) // RL16
    s_q.ovr_act |=> gate_on)
    else $error("Override active but gate not on");

  AST_FAULT_OFF: assert property (@(posedge clk) disable iff (reset) // RL6
    (!s_q.ovr_act && hv_fault) |=> !gate_on)
    else $error("HV fault did not hold gate off");

  AST_FS_CMD: assert property (@(posedge clk) disable iff (reset) // RL1
    (s_q.state == FSGA_FS_CTRL && !s_q.ovr_act && !hv_fault) |=> (gate_on == $past(cmd_f)))
    else $error("Fail-safe gate does not follow command");

  AST_FS_IGNORES_PWM: assert property (@(posedge clk) disable iff (reset) // RL2
    (s_q.state == FSGA_FS_CTRL && !s_q.ovr_act && !hv_fault && pwm_req && !cmd_f)
    |=> !gate_on)
    else $error("PWM reached gate in fail-safe");

  AST_IRQB_FS: assert property (@(posedge clk) disable iff (reset) // RL7
    (irq_b_reports_failsafe && !en_n_f) |=> !fault_irq_b_n)
    else $error("Interrupt B missed fail-safe report");

  AST_IRQB_QUIET: assert property (@(posedge clk) disable iff (reset) // RL7
    (!irq_b_reports_failsafe && !hv_fault && !ovr_f) |=> fault_irq_b_n)
    else $error("Interrupt B low without cause");

  AST_IRQB_OVR: assert property (@(posedge clk) disable iff (reset) // RL14
    ovr_f |=> (!fault_irq_b_n && fault_irq_a_n == $past(~hv_fault)))
    else $error("Override did not pull interrupt B low");

  AST_OVR_DELAY: assert property (@(posedge clk) disable iff (reset) // RL15
    $rose(ovr_f) |=> !s_q.ovr_act [*2])
    else $error("Override acted without its delay");

  AST_EXIT_SHORT: assert property (@(posedge clk) disable iff (reset) // RL12
    (s_q.state == FSGA_EXIT_WAIT && en_n_f && s_q.match && short_done)
    |=> s_q.state == FSGA_PWM_CTRL)
    else $error("Matching exit not handed over at short delay");

  AST_EXIT_HOLD: assert property (@(posedge clk) disable iff (reset) // RL8
    (s_q.state == FSGA_EXIT_WAIT && !short_done) |=> s_q.state != FSGA_PWM_CTRL)
    else $error("Handover before short exit delay");

  AST_EXIT_CHANGE: assert property (@(posedge clk) disable iff (reset) // RL9
    (s_q.state == FSGA_EXIT_WAIT && en_n_f && short_done && changed)
    |=> s_q.state == FSGA_PWM_CTRL)
    else $error("Input change did not hand over at once");

  AST_DEADTIME: assert property (@(posedge clk) disable iff (reset) // RL10
    (s_q.state == FSGA_PWM_CTRL && en_n_f && comp_f && !s_q.ovr_act
     && !(ovr_f && hv_override_enable)) |=> !gate_on [*2])
    else $error("Gate on inside deadtime");

  AST_FS_ENTRY: assert property (@(posedge clk) disable iff (reset) // RL1
    (s_q.state == FSGA_PWM_CTRL && !en_n_f) |=> s_q.state == FSGA_FS_CTRL)
    else $error("Low fail-safe enable did not enter fail-safe");

  AST_ENTRY_LEN: assert property (@(posedge clk) disable iff (reset) // RL5
    (en_n_f && cmd_f) |-> en_len == CW'(ENTRY_ON_CYC))
    else $error("Entry filter length ignores the command level");

  AST_EXIT_LONG: assert property (@(posedge clk) disable iff (reset) // RL8
    (s_q.state == FSGA_EXIT_WAIT && en_n_f && long_done) |=> s_q.state == FSGA_PWM_CTRL)
    else $error("Handover missed at long exit delay");

  AST_DT_RELOAD: assert property (@(posedge clk) disable iff (reset) // RL10
    comp_f |=> s_q.dt_cnt == CW'(DEADTIME_CYC))
    else $error("Deadtime not restarted by opposite side");

  AST_IRQ_FAULT: assert property (@(posedge clk) disable iff (reset) // RL14
    hv_fault |=> (!fault_irq_a_n && !fault_irq_b_n))
    else $error("Fault not shown on both interrupts");

  AST_OVR_NEEDS_EN: assert property (@(posedge clk) disable iff (reset) // RL19
    !hv_override_enable |=> !s_q.ovr_act)
    else $error("Override acted while disabled");

  AST_OVR_ACTS: assert property (@(posedge clk) disable iff (reset) // RL15
    (ovr_f && hv_override_enable && (s_q.ovr_cnt + CW'(1) >= CW'(OVR_CYC))) |=> s_q.ovr_act)
    else $error("Override not taken after its delay");

endmodule : fsga_arbiter

// File: core/fsga_filter.sv
// Two-flop synchroniser followed by a pulse suppression filter of run-time length
`timescale 1ns/10ps
module fsga_filter import fsga_pkg::*; #(
  parameter int CW = 16,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk, // 200 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire logic raw_in, // Asynchronous pin level
  input wire logic [CW-1:0] len, // Cycles the level must stand, at least 1
  output logic filt_out // Filtered level
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [CW-1:0] cnt;
    logic out;
  } fsga_filt_t;

  fsga_filt_t s_q;
  fsga_filt_t s_d;

  // ============================================================
  // Next state; sync1 is read only by sync2
  always_comb begin
    s_d = s_q;
    s_d.sync1 = raw_in;
    s_d.sync2 = s_q.sync1;
    if (s_q.sync2 == s_q.out) begin
      s_d.cnt = '0;
    end else if (s_q.cnt + CW'(1) >= len) begin
      s_d.out = s_q.sync2; // Level stood long enough
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
    if (reset) begin
      s_d = '{sync1: RST_VAL, sync2: RST_VAL, cnt: '0, out: RST_VAL};
    end
  end

  // State register
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign filt_out = s_q.out;

endmodule : fsga_filter

// File: core/fsga_pkg.sv
// Shared types of the fail-safe gate arbiter
package fsga_pkg;

  // ============================================================
  // Control owner of the gate, one-hot
  typedef enum logic [2:0] {
    FSGA_PWM_CTRL  = 3'b001,
    FSGA_FS_CTRL   = 3'b010,
    FSGA_EXIT_WAIT = 3'b100
  } fsga_state_t;

endpackage : fsga_pkg

// File: core/fsga_regs.svh
// Timing figures, derived cycle counts and reset values for the fail-safe gate arbiter
`ifndef FSGA_REGS_SVH
`define FSGA_REGS_SVH

// ============================================================
// Clock
`define FSGA_CLK_PERIOD_NS 5

// ============================================================
// Times in ns (least times, rounded up to whole cycles)
`define FSGA_IN_FILT_NS 40
`define FSGA_ENTRY_OFF_NS 1000
`define FSGA_ENTRY_ON_NS 2000
`define FSGA_EXIT_SHORT_NS 500
`define FSGA_EXIT_EXTRA_NS 6000
`define FSGA_EXIT_LONG_NS (`FSGA_EXIT_SHORT_NS + `FSGA_EXIT_EXTRA_NS)
`define FSGA_OVR_NS 1000
`define FSGA_DEADTIME_NS 250

// ============================================================
// Derived cycle counts
`define FSGA_CYC(ns) (((ns) + `FSGA_CLK_PERIOD_NS - 1) / `FSGA_CLK_PERIOD_NS)
`define FSGA_IN_FILT_CYC `FSGA_CYC(`FSGA_IN_FILT_NS)
`define FSGA_ENTRY_OFF_CYC `FSGA_CYC(`FSGA_ENTRY_OFF_NS)
`define FSGA_ENTRY_ON_CYC `FSGA_CYC(`FSGA_ENTRY_ON_NS)
`define FSGA_EXIT_SHORT_CYC `FSGA_CYC(`FSGA_EXIT_SHORT_NS)
`define FSGA_EXIT_LONG_CYC `FSGA_CYC(`FSGA_EXIT_LONG_NS)
`define FSGA_OVR_CYC `FSGA_CYC(`FSGA_OVR_NS)
`define FSGA_DEADTIME_CYC `FSGA_CYC(`FSGA_DEADTIME_NS)

// ============================================================
// Reset values
`define FSGA_RST_GATE 1'b0
`define FSGA_RST_IRQ_N 1'b1
`define FSGA_RST_EN_N 1'b1
`define FSGA_RST_COMP 1'b1
`define FSGA_RST_LOW 1'b0

`endif

// File: verification/fsga_arbiter_tb.sv
// Self-checking testbench of the fail-safe gate arbiter
`timescale 1ns/10ps
module fsga_arbiter_tb;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic hv_fault = 1'h0;
  logic hv_override_enable = 1'h0;
  logic irq_b_reports_failsafe = 1'h0;
  logic pwm_in;
  logic complementary_pwm_in;
  logic failsafe_enable_n;
  logic failsafe_gate_cmd;
  logic hv_override_in;
  logic gate_on;
  logic failsafe_active;
  logic fault_irq_a_n;
  logic fault_irq_b_n;
  logic status_override_level;
  logic status_gate_on;
  int failures = 0;
  int checked = 0;

  // ============================================================
  // Clock, partner and design with shortened counts
  always #2.5 clk = ~clk;

  fsga_partner #(.GAP_CYC(5)) fsga_partner_inst (
    .clk(clk),
    .pwm_in(pwm_in),
    .complementary_pwm_in(complementary_pwm_in),
    .failsafe_enable_n(failsafe_enable_n),
    .failsafe_gate_cmd(failsafe_gate_cmd),
    .hv_override_in(hv_override_in)
  );

  // Short counts keep the run small: filter 2, entry 20/30, exit 10/40, override 10
  fsga_arbiter #(.IN_FILT_CYC(2), .ENTRY_OFF_CYC(20), .ENTRY_ON_CYC(30),
    .EXIT_SHORT_CYC(10), .EXIT_LONG_CYC(40), .OVR_CYC(10), .DEADTIME_CYC(5)) fsga_arbiter_inst (
    .clk(clk),
    .reset(reset),
    .pwm_in(pwm_in),
    .complementary_pwm_in(complementary_pwm_in),
    .failsafe_enable_n(failsafe_enable_n),
    .failsafe_gate_cmd(failsafe_gate_cmd),
    .hv_override_in(hv_override_in),
    .hv_fault(hv_fault),
    .hv_override_enable(hv_override_enable),
    .irq_b_reports_failsafe(irq_b_reports_failsafe),
    .gate_on(gate_on),
    .failsafe_active(failsafe_active),
    .fault_irq_a_n(fault_irq_a_n),
    .fault_irq_b_n(fault_irq_b_n),
    .status_override_level(status_override_level),
    .status_gate_on(status_gate_on)
  );

  // ============================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic ck(input string name, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %b seen %b", name, exp, seen);
    end
  endtask : ck

  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the roughly 430 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_sim();
  end

  // ============================================================
  // Main sequence
  initial begin
    cyc(5);
    reset = 1'h0;
    ck("gate_on", gate_on, 1'h0);
    ck("irq_b", fault_irq_b_n, 1'h1);
    // Plain PWM, then the opposite side cuts the gate
    fsga_partner_inst.set_pwm(1'h1, 1'h0);
    cyc(20);
    ck("gate_on", gate_on, 1'h1);
    ck("status_gate", status_gate_on, 1'h1);
    fsga_partner_inst.set_pwm(1'h1, 1'h1);
    cyc(8);
    ck("gate_on", gate_on, 1'h0);
    fsga_partner_inst.set_pwm(1'h1, 1'h0);
    // Opposite side low again, but the deadtime still holds the gate off
    cyc(7);
    ck("gate_on", gate_on, 1'h0);
    cyc(13);
    // Entry with command low: the long filter holds PWM control first
    fsga_partner_inst.set_enable_n(1'h0);
    cyc(15);
    ck("fs_active", failsafe_active, 1'h0);
    cyc(15);
    ck("fs_active", failsafe_active, 1'h1);
    ck("gate_on", gate_on, 1'h0);
    ck("irq_b", fault_irq_b_n, 1'h1);
    irq_b_reports_failsafe = 1'h1;
    cyc(3);
    ck("irq_b", fault_irq_b_n, 1'h0);
    irq_b_reports_failsafe = 1'h0;
    // Exit with PWM differing from the command waits the long delay
    fsga_partner_inst.set_enable_n(1'h1);
    cyc(25);
    ck("fs_active", failsafe_active, 1'h1);
    cyc(30);
    ck("fs_active", failsafe_active, 1'h0);
    ck("gate_on", gate_on, 1'h1);
    // Entry with command high uses the longer filter
    fsga_partner_inst.set_cmd(1'h1);
    cyc(8);
    fsga_partner_inst.set_enable_n(1'h0);
    cyc(25);
    ck("fs_active", failsafe_active, 1'h0);
    cyc(15);
    ck("fs_active", failsafe_active, 1'h1);
    fsga_partner_inst.set_pwm(1'h0, 1'h0);
    cyc(10);
    ck("gate_on", gate_on, 1'h1);
    fsga_partner_inst.set_pwm(1'h1, 1'h0);
    cyc(8);
    // Matching exit hands over after the short delay only
    fsga_partner_inst.set_enable_n(1'h1);
    cyc(25);
    ck("fs_active", failsafe_active, 1'h0);
    ck("gate_on", gate_on, 1'h1);
    // Command change between the two exit limits hands over at once
    fsga_partner_inst.set_cmd(1'h0);
    cyc(8);
    fsga_partner_inst.set_enable_n(1'h0);
    cyc(30);
    ck("gate_on", gate_on, 1'h0);
    fsga_partner_inst.set_enable_n(1'h1);
    cyc(20);
    ck("fs_active", failsafe_active, 1'h1);
    fsga_partner_inst.set_cmd(1'h1);
    cyc(10);
    ck("fs_active", failsafe_active, 1'h0);
    ck("gate_on", gate_on, 1'h1);
    // Override pin while disabled: interrupt only, gate untouched
    fsga_partner_inst.set_enable_n(1'h0);
    cyc(40);
    fsga_partner_inst.set_override(1'h1);
    cyc(10);
    ck("irq_b", fault_irq_b_n, 1'h0);
    ck("ovr_level", status_override_level, 1'h1);
    ck("gate_on", gate_on, 1'h1);
    fsga_partner_inst.set_override(1'h0);
    cyc(10);
    ck("irq_b", fault_irq_b_n, 1'h1);
    // Fault holds the gate off despite the fail-safe command
    hv_fault = 1'h1;
    cyc(3);
    ck("gate_on", gate_on, 1'h0);
    ck("irq_a", fault_irq_a_n, 1'h0);
    // Enabled override outranks the fault after its delay
    hv_override_enable = 1'h1;
    fsga_partner_inst.set_override(1'h1);
    cyc(6);
    ck("gate_on", gate_on, 1'h0);
    cyc(20);
    ck("gate_on", gate_on, 1'h1);
    ck("status_gate", status_gate_on, 1'h1);
    ck("irq_a", fault_irq_a_n, 1'h0);
    // Clearing the enable with the pin still high gives the gate back to the fault
    hv_override_enable = 1'h0;
    cyc(3);
    ck("gate_on", gate_on, 1'h0);
    fsga_partner_inst.set_override(1'h0);
    cyc(8);
    ck("ovr_level", status_override_level, 1'h0);
    end_sim();
  end
endmodule : fsga_arbiter_tb

// File: verification/fsga_partner.sv
// Behavioural safing logic and PWM controller that drive the arbiter's pins
`timescale 1ns/10ps
module fsga_partner #(
  parameter int GAP_CYC = 5 // Quiet cycles before the fail-safe command turns the gate on
) (
  input wire logic clk, // Bench clock
  output logic pwm_in, // PWM pin
  output logic complementary_pwm_in, // Opposite-side PWM pin
  output logic failsafe_enable_n, // Fail-safe enable pin, active low
  output logic failsafe_gate_cmd, // Gate state wanted in fail-safe
  output logic hv_override_in // Override pin
);
  // ============================================================
  // Idle levels
  // Override held at ground level until a scenario needs it
  initial begin
    pwm_in = 1'h0;
    complementary_pwm_in = 1'h1;
    failsafe_enable_n = 1'h1;
    failsafe_gate_cmd = 1'h0;
    hv_override_in = 1'h0;
  end

  // ============================================================
  // Pin tasks, each change lands just after a rising edge
  task automatic set_pwm(input logic on, input logic comp);
    @(posedge clk);
    #1;
    pwm_in = on;
    complementary_pwm_in = comp;
  endtask : set_pwm

  // A turn-on waits out a deadtime gap, the arbiter no longer guards it
  task automatic set_cmd(input logic on);
    if (on) begin
      repeat (GAP_CYC) @(posedge clk);
    end
    @(posedge clk);
    #1;
    failsafe_gate_cmd = on;
  endtask : set_cmd

  task automatic set_enable_n(input logic v);
    @(posedge clk);
    #1;
    failsafe_enable_n = v;
  endtask : set_enable_n

  task automatic set_override(input logic v);
    @(posedge clk);
    #1;
    hv_override_in = v;
  endtask : set_override
endmodule : fsga_partner
